// ---- logic/pim_pkg.sv ----
// Constants and carrier types of the interrupt mask logic.
// Assumes a register access port from the management bus engine on the same clock.
// Behaviour
// [RL1] First mask register at subaddress 0x03, resets to 0x00, all unmasked.
// [RL2] Load-switch mask register at subaddress 0x04, resets to 0x00.
// [RL3] Mask bit 0: pending event pulls interrupt request low.
// [RL4] Mask bit 1: event has no effect on interrupt request.
// [RL5] Masking never stops events being detected and recorded in flags.
// [RL6] First mask bit 5 masks low programming voltage event.
// [RL7] First mask bit 4 masks supply-detect change event.
// [RL8] First mask bit 3 masks push-button change event.
// [RL9] First mask bit 2 masks thermal early-warning event.
// [RL10] First mask bit 1 masks coin-cell acquisition done event.
// [RL11] First mask bit 0 masks default-programming done event.
// [RL12] Second mask bits 5..3 mask switch three, two, one fault events.
// [RL13] Second mask bits 2..0 mask switch three, two, one limit events.
// [RL14] Switch event flags read-only at subaddress 0x02, reset 0x00.
// [RL15] Supply-detect change flag sets on either input edge.
// [RL16] Mask bits 7..6 read zero; request released when nothing unmasked pends.
`default_nettype none

package pim_pkg;

	localparam logic [7:0] PIM_ADDR_SWITCH_FLAGS = 8'h02;
	localparam logic [7:0] PIM_ADDR_MASK_ONE = 8'h03;
	localparam logic [7:0] PIM_ADDR_MASK_TWO = 8'h04;
	localparam logic [7:0] PIM_MASK_RESET = 8'h00;
	localparam logic [7:0] PIM_FLAG_RESET = 8'h00;
	localparam logic [7:0] PIM_MASK_WRITABLE = 8'h3f;
	localparam int PIM_BIT_PROG_VOLT = 5;
	localparam int PIM_BIT_SUPPLY = 4;
	localparam int PIM_BIT_BUTTON = 3;
	localparam int PIM_BIT_THERMAL = 2;
	localparam int PIM_BIT_COIN_CELL = 1;
	localparam int PIM_BIT_NVM_PROG = 0;
	localparam int PIM_BIT_SW3_FAULT = 5;
	localparam int PIM_BIT_SW2_FAULT = 4;
	localparam int PIM_BIT_SW1_FAULT = 3;
	localparam int PIM_BIT_SW3_LIMIT = 2;
	localparam int PIM_BIT_SW2_LIMIT = 1;
	localparam int PIM_BIT_SW1_LIMIT = 0;
	localparam logic [7:0] PIM_READ_IDLE = 8'h00;
	localparam logic [2:0] PIM_SYNC_RESET = 3'h0;

	// Register access from the bus engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pim_req_t;

	// Six event sources of the first group, bit order as the mask
	typedef struct packed {
		logic prog_volt_low;
		logic supply_change;
		logic button_change;
		logic thermal_warn;
		logic coin_cell_done;
		logic nvm_prog_done;
	} pim_grp1_t;

endpackage

`default_nettype wire

// ---- logic/pim_mask_logic.sv ----
// Interrupt mask registers, switch event flags and request output.
// Assumes the bus engine issues one-cycle rd/wr strobes and owns the first flag register.
`timescale 1ns/10ps
`default_nettype none

module pim_mask_logic
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register access
	input wire pim_pkg::pim_req_t req,
	output logic [7:0] rdata,
	output logic rvalid,
	// Event flags of the first group (recorded outside)
	input wire pim_pkg::pim_grp1_t grp1_flags,
	// Load switch event pulses, bit order fault3..1, limit3..1
	input wire logic [5:0] switch_events,
	// Supply detect pin
	input wire logic supply_detect_input,
	output logic supply_change_event,
	// Clear of switch flags on read (one cycle, from bus engine)
	input wire logic switch_flags_rd_clear,
	// Interrupt request pin, open drain
	output logic irq_request_n_out,
	output logic irq_request_n_oe_n
);
	import pim_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	logic [7:0] event_mask_group_one;
	logic [7:0] switch_event_mask;
	logic [7:0] switch_event_flags;
	logic [7:0] next_switch_event_flags;
	logic [7:0] grp1_flag_bits;
	logic [7:0] grp1_mask_bits;
	logic [7:0] switch_mask_bits;
	logic [7:0] grp1_unmasked;
	logic [7:0] switch_unmasked;
	logic [2:0] supply_sync;
	logic mask_one_wr;
	logic mask_two_wr;
	logic irq_pending;

	// Named mask fields of both registers
	logic low_program_voltage_mask;
	logic supply_detect_change_mask;
	logic button_change_mask;
	logic thermal_warning_mask;
	logic coin_cell_done_mask;
	logic nvm_program_done_mask;
	logic switch3_fault_mask;
	logic switch2_fault_mask;
	logic switch1_fault_mask;
	logic switch3_limit_mask;
	logic switch2_limit_mask;
	logic switch1_limit_mask;

	// ****************************************
	// Decoding
	// ****************************************
	// Write strobe for one subaddress
	function automatic logic write_hit(
		input pim_req_t r,
		input logic [7:0] a
	);
	begin
		return r.wr && (r.addr == a);
	end
	endfunction

	// Read data for one subaddress, spare addresses read zero
	function automatic logic [7:0] read_select(
		input logic [7:0] a,
		input logic [7:0] flags,
		input logic [7:0] mask_one,
		input logic [7:0] mask_two
	);
	begin
		unique case (a)
			PIM_ADDR_SWITCH_FLAGS: read_select = flags;
			PIM_ADDR_MASK_ONE: read_select = mask_one;
			PIM_ADDR_MASK_TWO: read_select = mask_two;
			default: read_select = PIM_READ_IDLE;
		endcase
	end
	endfunction

	assign mask_one_wr = write_hit(req, PIM_ADDR_MASK_ONE);
	assign mask_two_wr = write_hit(req, PIM_ADDR_MASK_TWO);

	// ****************************************
	// Mask registers
	// ****************************************
	// [RL1] first mask reset and write
	always_ff @(posedge clock)
	begin
		if (rst)
			event_mask_group_one <= PIM_MASK_RESET;
		else if (mask_one_wr)
			// [RL16] upper bits stay zero
			event_mask_group_one <= req.wdata & PIM_MASK_WRITABLE;
	end

	// [RL2] second mask reset and write
	always_ff @(posedge clock)
	begin
		if (rst)
			switch_event_mask <= PIM_MASK_RESET;
		else if (mask_two_wr)
			// [RL16] upper bits stay zero
			switch_event_mask <= req.wdata & PIM_MASK_WRITABLE;
	end

	// ****************************************
	// Mask fields
	// ****************************************
	// [RL6] programming voltage
	assign low_program_voltage_mask = event_mask_group_one[PIM_BIT_PROG_VOLT];
	// [RL7] supply detect change
	assign supply_detect_change_mask = event_mask_group_one[PIM_BIT_SUPPLY];
	// [RL8] button change
	assign button_change_mask = event_mask_group_one[PIM_BIT_BUTTON];
	// [RL9] thermal warning
	assign thermal_warning_mask = event_mask_group_one[PIM_BIT_THERMAL];
	// [RL10] coin cell done
	assign coin_cell_done_mask = event_mask_group_one[PIM_BIT_COIN_CELL];
	// [RL11] programming done
	assign nvm_program_done_mask = event_mask_group_one[PIM_BIT_NVM_PROG];
	// [RL12] switch fault masks
	assign switch3_fault_mask = switch_event_mask[PIM_BIT_SW3_FAULT];
	assign switch2_fault_mask = switch_event_mask[PIM_BIT_SW2_FAULT];
	assign switch1_fault_mask = switch_event_mask[PIM_BIT_SW1_FAULT];
	// [RL13] switch limit masks
	assign switch3_limit_mask = switch_event_mask[PIM_BIT_SW3_LIMIT];
	assign switch2_limit_mask = switch_event_mask[PIM_BIT_SW2_LIMIT];
	assign switch1_limit_mask = switch_event_mask[PIM_BIT_SW1_LIMIT];

	// Mask views, bit order as the flags
	assign grp1_mask_bits = {2'h0, low_program_voltage_mask, supply_detect_change_mask,
		button_change_mask, thermal_warning_mask, coin_cell_done_mask, nvm_program_done_mask};
	assign switch_mask_bits = {2'h0, switch3_fault_mask, switch2_fault_mask,
		switch1_fault_mask, switch3_limit_mask, switch2_limit_mask, switch1_limit_mask};

	// ****************************************
	// Supply detect edge
	// ****************************************
	// Two flops against metastability, a third for the edge
	always_ff @(posedge clock)
	begin
		if (rst)
			supply_sync <= PIM_SYNC_RESET;
		else
			supply_sync <= {supply_sync[1:0], supply_detect_input};
	end

	// [RL15] either edge sets change
	assign supply_change_event = supply_sync[2] ^ supply_sync[1];

	// ****************************************
	// Switch event flags
	// ****************************************
	// [RL14] [RL5] sticky, set wins over clear, mask not consulted
	generate
		for (genvar gi = 0; gi < 8; gi++)
		begin : g_flag
			if (gi < 6)
			begin : g_live
				assign next_switch_event_flags[gi] = switch_events[gi]
					| (switch_event_flags[gi] & ~switch_flags_rd_clear);
			end
			else
			begin : g_spare
				// [RL16] no source
				assign next_switch_event_flags[gi] = 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge clock)
	begin
		if (rst)
			switch_event_flags <= PIM_FLAG_RESET;
		else
			switch_event_flags <= next_switch_event_flags;
	end

	// ****************************************
	// Read path
	// ****************************************
	always_ff @(posedge clock)
	begin
		if (rst)
			rvalid <= 1'b0;
		else
			rvalid <= req.rd;
	end

	// Data follows the address every cycle, taken with rvalid
	always_ff @(posedge clock)
	begin
		if (rst)
			rdata <= PIM_READ_IDLE;
		else
			rdata <= read_select(req.addr, switch_event_flags, event_mask_group_one,
				switch_event_mask);
	end

	// ****************************************
	// Interrupt request
	// ****************************************
	// [RL3] [RL4] per-bit gating by mask
	generate
		for (genvar gj = 0; gj < 8; gj++)
		begin : g_gate
			assign grp1_unmasked[gj] = grp1_flag_bits[gj] & ~grp1_mask_bits[gj];
			assign switch_unmasked[gj] = switch_event_flags[gj] & ~switch_mask_bits[gj];
		end
	endgenerate

	assign grp1_flag_bits = {2'h0, grp1_flags};
	assign irq_pending = (|grp1_unmasked) | (|switch_unmasked);

	// [RL16] released when nothing pends
	always_ff @(posedge clock)
	begin
		if (rst)
			irq_request_n_oe_n <= 1'b1;
		else
			irq_request_n_oe_n <= ~irq_pending;
	end

	// Open drain: data stays low, only the enable moves
	assign irq_request_n_out = 1'b0;

endmodule // pim_mask_logic

`default_nettype wire

// ---- bench/pim_flag_model.sv ----
// Outside flag store fed by the supply change pulse.
`timescale 1ns/10ps
`default_nettype none
module pim_flag_model (
	input wire logic clock, rst, set_pulse,
	output logic flag
);
	always_ff @(posedge clock)
		flag <= !rst && (flag || set_pulse);
endmodule // pim_flag_model
`default_nettype wire

// ---- bench/pim_mask_properties.sv ----
// Port checker, bound to the mask logic.
`timescale 1ns/10ps
`default_nettype none
module pim_mask_properties (
	input wire logic clock, rst, rvalid,
	input wire pim_pkg::pim_req_t req,
	input wire logic [7:0] rdata,
	input wire logic supply_detect_input, supply_change_event,
	input wire logic irq_request_n_out, irq_request_n_oe_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_rd_answer: assert property (req.rd |=> rvalid) else $error("no rvalid");
	a_rd_idle: assert property (!req.rd |=> !rvalid) else $error("stray rvalid");
	a_spare_zero: assert property
		(req.rd && (req.addr < 8'h02 || req.addr > 8'h04) |=> rdata == 8'h00) else $error("spare");
	a_top_zero: assert property (rvalid |-> rdata[7:6] == 2'b00) else $error("top");
	a_reset_quiet: assert property
		($fell(rst) |-> irq_request_n_oe_n && !rvalid) else $error("reset");
	a_pin_low: assert property (irq_request_n_out == 1'b0) else $error("pin");
	a_edge_seen: assert property
		($changed(supply_detect_input) |-> ##[1:3] supply_change_event) else $error("edge");
	a_edge_pulse: assert property
		(supply_change_event |=> !supply_change_event) else $error("pulse");
	c_write: cover property (req.wr);
	c_irq: cover property ($fell(irq_request_n_oe_n));
	c_edge: cover property (supply_change_event);
endmodule // pim_mask_properties
bind pim_mask_logic pim_mask_properties chk (.*);
`default_nettype wire

// ---- bench/testbench.sv ----
// Register and pin tests of the mask logic.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import pim_pkg::*;
	logic clock = 0, rst = 1, sup = 0, clr = 0, sf, ev, rvalid, pin, oe_n;
	logic [5:0] sw = '0;
	logic [7:0] rdata;
	pim_req_t req = '0;
	pim_grp1_t g1 = '0;
	int err_count = 0, checked = 0;
	pim_mask_logic dut (.clock, .rst, .req, .rdata, .rvalid, .grp1_flags(g1 | {1'b0, sf, 4'h0}),
		.switch_events(sw), .supply_detect_input(sup), .supply_change_event(ev),
		.switch_flags_rd_clear(clr), .irq_request_n_out(pin), .irq_request_n_oe_n(oe_n));
	pim_flag_model far (.clock, .rst, .set_pulse(ev), .flag(sf));
	initial
		forever #50 clock = ~clock;
	task automatic chk(input logic [8:0] s, e);
		checked++;
		if (s !== e)
		begin
			err_count++;
			$display("unexpected at %0t: %h vs %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(negedge clock) req = '{1'b1, 1'b0, a, d};
		@(negedge clock) req = '0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(negedge clock) req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clock) req = '0;
		chk({rvalid, rdata}, {1'b1, e});
	endtask
	task automatic wt(input logic e);
		repeat (4) @(negedge clock);
		chk(oe_n, e);
	endtask
	task automatic report_and_stop;
		if (err_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(negedge clock);
		rst = 0;
		rd(8'h03, 8'h00);
		rd(8'h04, 8'h00);
		rd(8'h02, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			g1 = 6'h01 << i;
			wr(8'h03, 8'h01 << i);
			wt(1);
			wr(8'h03, 8'hff ^ (8'h01 << i));
			wt(0);
		end
		g1 = '0;
		for (int i = 0; i < 6; i++)
		begin
			wr(8'h04, 8'h01 << i);
			@(negedge clock) sw = 6'h01 << i;
			@(negedge clock) sw = '0;
			wt(1);
			rd(8'h02, 8'h01 << i);
			wr(8'h04, 8'hff ^ (8'h01 << i));
			wt(0);
			@(negedge clock) clr = 1;
			@(negedge clock) clr = 0;
			wt(1);
		end
		rd(8'h04, 8'h1f);
		wr(8'h03, 8'hff);
		rd(8'h03, 8'h3f);
		sup = 1;
		wt(1);
		chk(sf, 1);
		sup = 0;
		wt(1);
		wr(8'h02, 8'hff);
		rd(8'h02, 8'h00);
		rd(8'h05, 8'h00);
		report_and_stop;
	end
endmodule // testbench
`default_nettype wire
